// File: common/current_sense_map.svh
// constants for the current-sense configuration and fault counter
`ifndef CURRENT_SENSE_MAP_SVH
`define CURRENT_SENSE_MAP_SVH
`define CSC_OFFSET        8'hd0
`define CSC_RESET         16'h620e
`define CSC_BLANK_MSB     15
`define CSC_BLANK_LSB     11
`define CSC_COUNT_MSB     10
`define CSC_COUNT_LSB     8
`define CSC_METHOD_MSB    3
`define CSC_METHOD_LSB    2
`define CSC_RANGE_MSB     1
`define CSC_RANGE_LSB     0
`define CSC_WMASK         16'hff0f
`define CSC_BLANK_STEP_NS 32
`define CSC_BLANK_MAX     5'h1a
`define CSC_PAGES         2
`endif

// File: common/current_sense_pkg.sv
// types for the current-sense configuration block
package current_sense_pkg;
    typedef enum logic [1:0] {
        method_unused,
        inductor_resistance_sensing_down,
        inductor_resistance_sensing_up,
        stage_monitor_sensing
    } sense_method_t;
    typedef enum logic [1:0] {
        range_low,
        range_medium,
        range_high,
        range_unused
    } sense_range_t;
    typedef struct packed {
        logic [4:0]    blank;
        logic [2:0]    count;
        logic [3:0]    unused;
        sense_method_t method;
        sense_range_t  range;
    } current_sense_config_t;
    typedef struct packed {
        logic [4:0]    blank;
        logic [3:0]    events_needed;
        sense_method_t method;
        sense_range_t  range;
    } sense_setup_t;
endpackage

// File: logic/fault_counter.sv
// consecutive overcurrent / undercurrent event counter for one page
`timescale 1ns/1ps
`default_nettype none
module fault_counter
    import current_sense_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // switching cycle strobe and event
    input  wire logic       i_cycle_end,
    input  wire logic       i_event,
    input  wire logic [3:0] i_needed,
    // result
    output logic      [3:0] o_count,
    output logic            o_fault
);
    logic [3:0] count_q, count_d;
    logic       fault_q, fault_d;

    always_comb begin
        count_d = count_q;
        fault_d = fault_q;
        if (i_cycle_end) begin
            if (i_event) begin
                // saturate so a long fault does not wrap
                if (count_q < i_needed) begin
                    count_d = count_q + 4'h1;
                end
                // one bit wider so a count of 15 cannot wrap to zero
                fault_d = (({1'b0, count_q} + 5'h01) >= {1'b0, i_needed});
            end else begin
                count_d = 4'h0;
                fault_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_q <= 4'h0;
            fault_q <= 1'b0;
        end else begin
            count_q <= count_d;
            fault_q <= fault_d;
        end
    end

    assign o_count = count_q;
    assign o_fault = fault_q;

    chk_clean_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cycle_end && !i_event) |=> (count_q == 4'h0 && !fault_q))
        else $error("clean cycle did not clear counter");
    chk_fault_needs_count: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(fault_q) |-> (count_q >= i_needed && $past(i_cycle_end) && $past(i_event)))
        else $error("fault raised before enough events");
    chk_one_per_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_cycle_end |=> (count_q == $past(count_q)))
        else $error("counter moved without cycle strobe");
endmodule
`default_nettype wire

// File: logic/current_sense_config.sv
// paged current-sense configuration word and fault detection
`include "current_sense_map.svh"
`timescale 1ns/1ps
`default_nettype none
module current_sense_config
    import current_sense_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // command port from the bus engine
    input  wire logic        i_page,
    input  wire logic [7:0]  i_cmd,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_rvalid,
    output logic             o_hit,
    // switching cycle and analog events per page
    input  wire logic [1:0]  i_cycle_end,
    input  wire logic [1:0]  i_overcurrent_event,
    input  wire logic [1:0]  i_undercurrent_event,
    // per-page setup and fault
    output sense_setup_t     o_setup0,
    output sense_setup_t     o_setup1,
    output logic      [1:0]  o_fault
);
    current_sense_config_t cfg_q [`CSC_PAGES];
    current_sense_config_t cfg_d [`CSC_PAGES];
    logic [15:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d, hit_q, hit_d;
    sense_setup_t setup_q [`CSC_PAGES];
    sense_setup_t setup_d [`CSC_PAGES];
    logic [1:0]  fault_w, fault_q;
    logic        sel;

    assign sel = (i_cmd == `CSC_OFFSET);

    genvar p;
    generate
        for (p = 0; p < `CSC_PAGES; p++) begin : g_page
            logic [3:0] needed;
            logic       wr_here;
            assign wr_here = i_wr && sel && (i_page == 1'(p));
            always_comb begin
                cfg_d[p] = cfg_q[p];
                // only the selected page takes the write; unused bits stay 0
                if (wr_here) begin
                    cfg_d[p] = current_sense_config_t'(i_wdata & `CSC_WMASK);
                end
                // blanking codes past 832 ns clamp to the top step
                if (wr_here && (i_wdata[`CSC_BLANK_MSB:`CSC_BLANK_LSB] > `CSC_BLANK_MAX)) begin
                    cfg_d[p].blank = `CSC_BLANK_MAX;
                end
            end
            assign needed = {cfg_q[p].count, 1'b1};
            always_comb begin
                setup_d[p].blank         = cfg_q[p].blank;
                setup_d[p].events_needed = needed;
                setup_d[p].method        = cfg_q[p].method;
                setup_d[p].range         = cfg_q[p].range;
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cfg_q[p]   <= current_sense_config_t'(`CSC_RESET);
                    setup_q[p] <= '0;
                end else begin
                    cfg_q[p]   <= cfg_d[p];
                    setup_q[p] <= setup_d[p];
                end
            end
            fault_counter u_count (
                .i_clk       (i_clk),
                .i_rst_n     (i_rst_n),
                .i_cycle_end (i_cycle_end[p]),
                .i_event     (i_overcurrent_event[p] | i_undercurrent_event[p]),
                .i_needed    (needed),
                .o_count     (),
                .o_fault     (fault_w[p])
            );
            chk_page_isolated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                !(i_wr && sel && i_page == 1'(p)) |=> (cfg_q[p] == $past(cfg_q[p])))
                else $error("page changed without its own write");
        end
    endgenerate

    always_comb begin
        rdata_d  = 16'h0000;
        rvalid_d = i_rd;
        hit_d    = (i_rd || i_wr) && sel;
        if (i_rd && sel) begin
            rdata_d = cfg_q[i_page];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
            hit_q    <= 1'b0;
            fault_q  <= 2'b00;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            hit_q    <= hit_d;
            fault_q  <= fault_w;
        end
    end

    assign o_rdata  = rdata_q;
    assign o_rvalid = rvalid_q;
    assign o_hit    = hit_q;
    assign o_fault  = fault_q;
    assign o_setup0 = setup_q[0];
    assign o_setup1 = setup_q[1];

    chk_reset_value: assert property (@(posedge i_clk)
        !i_rst_n |=> (cfg_q[0] == `CSC_RESET && cfg_q[1] == `CSC_RESET))
        else $error("reset value not loaded");
    chk_read_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && sel && i_wdata[15:11] <= 5'h1a) ##1 (i_rd && sel && i_page == $past(i_page))
        |=> (o_rdata == ($past(i_wdata, 2) & 16'hff0f)))
        else $error("written word not read back");
    chk_blank_clamp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_setup0.blank <= 5'h1a) && (o_setup1.blank <= 5'h1a))
        else $error("blanking code out of range");
    chk_count_odd: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rst_n |=> (o_setup0.events_needed == {$past(cfg_q[0].count), 1'b1}))
        else $error("event count not twice code plus one");
    chk_method_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rst_n |=> (o_setup1.method == $past(cfg_q[1].method)
             && o_setup1.range == $past(cfg_q[1].range)))
        else $error("method or range not passed through");
    chk_fault_clean: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cycle_end[0] && !i_overcurrent_event[0] && !i_undercurrent_event[0])
        |-> ##2 !o_fault[0])
        else $error("fault held after clean cycle");
endmodule
`default_nettype wire

// File: verification/bus_host_model.sv
// behavioural bus host issuing config word commands
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
    // clock
    input  wire logic        i_clk,
    // command port toward the block
    output logic             o_page,
    output logic      [7:0]  o_cmd,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_wdata,
    // answer from the block
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    input  wire logic        i_hit
);
    logic [15:0] rdata;
    logic        rvalid;
    logic        hit;
    initial begin
        o_page  = 1'b0;
        o_cmd   = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end
    // one strobe per call, answer taken one cycle later
    task automatic xfer(input logic wr, input logic page, input logic [7:0] cmd,
                        input logic [15:0] wd);
        @(negedge i_clk);
        o_page  = page;
        o_cmd   = cmd;
        o_wr    = wr;
        o_rd    = ~wr;
        o_wdata = wd;
        @(negedge i_clk);
        rdata   = i_rdata;
        rvalid  = i_rvalid;
        hit     = i_hit;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        // released data never repeats its last value
        o_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// File: verification/current_sense_config_bench.sv
// self-checking bench for the paged current-sense config block
`timescale 1ns/1ps
`default_nettype none
module current_sense_config_bench;
    import current_sense_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        page, wr, rd;
    logic [7:0]  cmd;
    logic [15:0] wdata, rdata;
    logic        rvalid, hit;
    logic [1:0]  cyc = 2'b00, oc = 2'b00, uc = 2'b00, fault;
    sense_setup_t s0, s1;
    int          fails = 0;
    int          cmp_count = 0;
    always #20 i_clk = ~i_clk;
    bus_host_model host (.i_clk(i_clk), .o_page(page), .o_cmd(cmd), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid), .i_hit(hit));
    current_sense_config DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_page(page), .i_cmd(cmd),
        .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_hit(hit), .i_cycle_end(cyc), .i_overcurrent_event(oc),
        .i_undercurrent_event(uc), .o_setup0(s0), .o_setup1(s1), .o_fault(fault));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic read_word(input logic pg, input logic [15:0] exp);
        host.xfer(1'b0, pg, 8'hd0, 16'h0000);
        check("rvalid", {15'h0, host.rvalid}, 16'h0001);
        check("hit", {15'h0, host.hit}, 16'h0001);
        check("rdata", host.rdata, exp);
    endtask
    task automatic test_reset;
        read_word(1'b0, 16'h620e);
        read_word(1'b1, 16'h620e);
        check("setup1", {3'h0, s1}, {3'h0, 5'h0c, 4'h5, 2'h3, 2'h2});
        $display("test reset done");
    endtask
    // unused bits dropped, other page untouched, medium range code 01
    task automatic test_write;
        host.xfer(1'b1, 1'b0, 8'hd0, 16'hd7f5);
        read_word(1'b0, 16'hd705);
        read_word(1'b1, 16'h620e);
        check("setup0", {3'h0, s0}, {3'h0, 5'h1a, 4'hf, 2'h1, 2'h1});
        host.xfer(1'b1, 1'b0, 8'hd0, 16'hf800);
        read_word(1'b0, 16'hd000);
        host.xfer(1'b1, 1'b0, 8'hd0, 16'h0008);
        // setup is one register behind the word
        @(negedge i_clk);
        check("setup0b", {3'h0, s0}, {3'h0, 5'h00, 4'h1, 2'h2, 2'h0});
        host.xfer(1'b0, 1'b0, 8'hd1, 16'h0000);
        check("foreign", {host.hit, host.rdata[14:0]}, 16'h0000);
        $display("test write done");
    endtask
    // one switching cycle; fault sampled two edges after the strobe
    task automatic cycle(input logic [1:0] o, input logic [1:0] u, input logic [1:0] expf);
        @(negedge i_clk);
        cyc = 2'b11;
        oc = o;
        uc = u;
        @(negedge i_clk);
        cyc = 2'b00;
        oc = 2'b00;
        uc = 2'b00;
        @(negedge i_clk);
        check("fault", {14'h0, fault}, {14'h0, expf});
    endtask
    // page1 needs 5, page0 needs 1; a clean cycle clears both
    task automatic test_fault;
        cycle(2'b00, 2'b00, 2'b00);
        for (int i = 1; i < 5; i++) cycle({1'b1, i[0]}, {1'b0, ~i[0]}, 2'b01);
        cycle(2'b10, 2'b00, 2'b10);
        cycle(2'b00, 2'b10, 2'b10);
        cycle(2'b00, 2'b00, 2'b00);
        $display("test fault done");
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
        test_reset();
        test_write();
        test_fault();
        close_out();
    end
    initial begin
        #(40 * 2000);
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
